// ===== logic/clock_switch_pkg.sv
`default_nettype none
package clock_switch_pkg;

    // guard and stuck detection, in clk cycles
    localparam int unsigned stuck_cycles       = 8;
    localparam int unsigned idle_cnt_w         = 4;
    // switchover stage lengths, in new-clock pulses / falling edges
    localparam int unsigned hold_pulses        = 2;
    localparam int unsigned low_edges          = 2;
    localparam int unsigned stage_cnt_w        = 5;
    // bound on new-clock cycles from select change to following
    localparam int unsigned max_switch_cycles  = 17;
    // power-up initialisation length, default in clk cycles
    localparam int unsigned por_cycles_default = 16;
    localparam int unsigned por_cnt_w          = 16;

    typedef enum logic [1:0] {st_follow, st_drain, st_high, st_low} sw_state_t;

    // one clock input as seen at the pins: sampled level and amplitude-ok flag
    typedef struct packed {
        logic raw;
        logic valid;
    } clock_pin_t;

    // what one lane reports to the switch
    typedef struct packed {
        logic level;
        logic rise;
        logic fall;
        logic stuck;
    } lane_status_t;

    typedef struct packed {
        logic                  level;
        logic                  rise;
        logic                  fall;
        logic                  stuck;
        logic [idle_cnt_w-1:0] idle;
    } lane_state_t;

    typedef struct packed {
        sw_state_t              state;
        logic                   sel_meta;
        logic                   sel_sync;
        logic                   cur;
        logic [stage_cnt_w-1:0] cnt;
        logic                   out;
        logic                   busy;
        logic                   por_done;
        logic [por_cnt_w-1:0]   por_cnt;
    } switch_state_t;

    localparam logic [idle_cnt_w-1:0] idle_stuck = idle_cnt_w'(stuck_cycles);

endpackage
`default_nettype wire

// ===== logic/clock_lane.sv
`default_nettype none
// failsafe_input_guard for one clock input, plus edge and stuck detection
module clock_lane
(
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire clock_switch_pkg::clock_pin_t  pin,
    output      clock_switch_pkg::lane_status_t status
);
    import clock_switch_pkg::*;

    lane_state_t s_q;
    lane_state_t s_d;

    always_comb
    begin
        s_d      = s_q;
        // hold the last valid level while the amplitude is lost
        if (pin.valid)
        begin
            s_d.level = pin.raw;
        end
        s_d.rise = s_d.level & ~s_q.level;
        s_d.fall = ~s_d.level & s_q.level;
        if (s_d.rise | s_d.fall)
        begin
            s_d.idle = '0;
        end
        else if (s_q.idle != idle_stuck)
        begin
            s_d.idle = s_q.idle + idle_cnt_w'(1);
        end
        // a slowly degrading but toggling input still passes edges
        s_d.stuck = (s_d.idle == idle_stuck);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign status = '{level: s_q.level, rise: s_q.rise, fall: s_q.fall, stuck: s_q.stuck};

    a_guard_hold: assert property (@(posedge clk) disable iff (rst)
        !pin.valid |=> $stable(s_q.level))
        else $error("guarded level moved while input invalid");

    a_stuck_edge: assert property (@(posedge clk) disable iff (rst)
        (s_q.rise | s_q.fall) |-> !s_q.stuck ##1 !s_q.stuck)
        else $error("stuck flagged right after an edge");

endmodule
`default_nettype wire

// ===== logic/glitchless_clock_switch.sv
`default_nettype none
module glitchless_clock_switch
#(
    parameter int unsigned por_cycles = clock_switch_pkg::por_cycles_default
)
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic clock_input_a,
    input  wire logic clock_input_a_ok,
    input  wire logic clock_input_b,
    input  wire logic clock_input_b_ok,
    input  wire logic select_b,
    input  wire logic delay_capacitor_pin,
    output      logic clock_out,
    output      logic switching,
    output      logic active_b
);
    import clock_switch_pkg::*;

    clock_pin_t    pins [2];
    lane_status_t  lane [2];
    switch_state_t s_q;
    switch_state_t s_d;
    logic          nw;

    assign pins[0] = '{raw: clock_input_a, valid: clock_input_a_ok};
    assign pins[1] = '{raw: clock_input_b, valid: clock_input_b_ok};

    ////////////////////////////////////////////////////////////////////////////
    // identical lanes, so neither input is special

    for (genvar i = 0; i < 2; i++)
    begin : g_lane
        clock_lane u_lane
        (
            .clk    (clk),
            .rst    (rst),
            .pin    (pins[i]),
            .status (lane[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // switch sequencer; cur names the old clock until the new one is followed

    assign nw = ~s_q.cur;

    always_comb
    begin
        s_d          = s_q;
        s_d.sel_meta = select_b;
        s_d.sel_sync = s_q.sel_meta;
        if (!s_q.por_done)
        begin
            // known state until the initialisation count runs out
            s_d.por_cnt  = s_q.por_cnt + por_cnt_w'(1);
            s_d.por_done = (s_q.por_cnt == por_cnt_w'(por_cycles - 1));
            s_d.cur      = s_q.sel_sync;
            s_d.state    = st_follow;
            s_d.out      = 1'b0;
        end
        else if (delay_capacitor_pin)
        begin
            s_d.cur   = s_q.sel_sync;
            s_d.state = st_follow;
            s_d.out   = lane[s_q.sel_sync].level;
        end
        else
        begin
            case (s_q.state)
                st_follow:
                begin
                    s_d.out = lane[s_q.cur].level;
                    s_d.cnt = '0;
                    if (s_q.sel_sync != s_q.cur)
                    begin
                        // a dead old clock takes the path of its last valid level
                        if (lane[s_q.cur].stuck)
                        begin
                            s_d.state = lane[s_q.cur].level ? st_high : st_low;
                        end
                        else
                        begin
                            s_d.state = st_drain;
                        end
                    end
                end
                st_drain:
                begin
                    // keep the old clock until its low phase, so no high runt
                    s_d.out = lane[s_q.cur].level;
                    if (!lane[s_q.cur].level)
                    begin
                        s_d.state = st_low;
                        s_d.out   = 1'b0;
                    end
                    else if (lane[s_q.cur].stuck)
                    begin
                        s_d.state = st_high;
                    end
                end
                st_high:
                begin
                    s_d.out = 1'b1;
                    if (lane[nw].rise && s_q.cnt != stage_cnt_w'(hold_pulses))
                    begin
                        s_d.cnt = s_q.cnt + stage_cnt_w'(1);
                    end
                    // leave on a new falling edge: high spans whole new pulses
                    if (lane[nw].fall && s_q.cnt == stage_cnt_w'(hold_pulses))
                    begin
                        s_d.state = st_low;
                        s_d.cnt   = '0;
                        s_d.out   = 1'b0;
                    end
                end
                st_low:
                begin
                    s_d.out = 1'b0;
                    if (lane[nw].fall)
                    begin
                        s_d.cnt = s_q.cnt + stage_cnt_w'(1);
                        // hand over right after a new fall, so the low phase stays whole
                        if (s_q.cnt == stage_cnt_w'(low_edges - 1))
                        begin
                            s_d.state = st_follow;
                            s_d.cur   = nw;
                            s_d.cnt   = '0;
                        end
                    end
                end
                default:
                begin
                    s_d.state = st_follow;
                end
            endcase
        end
        s_d.busy = (s_d.state != st_follow);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign clock_out = s_q.out;
    assign switching = s_q.busy;
    assign active_b  = s_q.cur;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    logic [stage_cnt_w:0] sw_rises_q;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sw_rises_q <= '0;
        end
        else if (!s_q.busy)
        begin
            sw_rises_q <= '0;
        end
        else if (lane[nw].rise && sw_rises_q != '1)
        begin
            sw_rises_q <= sw_rises_q + (stage_cnt_w + 1)'(1);
        end
    end

    a_switch_bound: assert property (@(posedge clk) disable iff (rst)
        sw_rises_q <= (stage_cnt_w + 1)'(max_switch_cycles))
        else $error("switchover took too many new-clock cycles");

    a_low_stage: assert property (@(posedge clk) disable iff (rst)
        s_q.state == st_low |-> !clock_out)
        else $error("output high during low stage");

    a_high_stage: assert property (@(posedge clk) disable iff (rst)
        s_q.por_done && !delay_capacitor_pin && $past(s_q.state) == st_high && s_q.state == st_high |-> clock_out)
        else $error("output low during stuck-high stage");

    a_follow_clock: assert property (@(posedge clk) disable iff (rst)
        s_q.por_done && !delay_capacitor_pin && $past(s_q.state) == st_follow && s_q.state == st_follow
        && $past(s_q.por_done)
        && $past(s_q.cur) == s_q.cur && $past(s_q.sel_sync) == s_q.cur |-> clock_out == $past(lane[s_q.cur].level))
        else $error("output does not follow the selected clock");

    a_bypass_mux: assert property (@(posedge clk) disable iff (rst)
        s_q.por_done && delay_capacitor_pin |=> !s_q.busy && s_q.cur == $past(s_q.sel_sync))
        else $error("plain mux did not switch at once");

    a_sel_sync: assert property (@(posedge clk) disable iff (rst)
        ##2 s_q.sel_sync == $past(select_b, 2))
        else $error("select sync is not two stages");

    a_handover_low: assert property (@(posedge clk) disable iff (rst)
        s_q.por_done && !delay_capacitor_pin && $past(s_q.state) == st_low && s_q.state == st_follow
        |-> !clock_out && s_q.cur != $past(s_q.cur))
        else $error("handover not at a new-clock low phase");

    a_por_quiet: assert property (@(posedge clk) disable iff (rst)
        !s_q.por_done |-> !clock_out && !s_q.busy)
        else $error("output active before initialisation ends");

endmodule
`default_nettype wire

// ===== bench/clock_source_model.sv
`default_nettype none
// two clock sources sampled on clk; a failed source flips every cycle so its level is never trusted
module clock_source_model
#(
    parameter int half_a = 4, // 5:4 stays within 1.5:1
    parameter int half_b = 5
)
(
    input  wire logic       clk,
    input  wire logic [1:0] stop,
    input  wire logic [1:0] fail,
    output      logic [1:0] raw = '0,
    output      logic [1:0] ok  = 2'h3
);
    timeunit 1ns;
    timeprecision 1ps;
    int         cnt [2] = '{0, 0};
    logic [1:0] lvl     = '0;

    always @(negedge clk)
    begin
        for (int i = 0; i < 2; i++)
        begin
            if (!stop[i])
            begin
                cnt[i] = cnt[i] + 1;
                if (cnt[i] >= (i == 1 ? half_b : half_a))
                begin
                    cnt[i] = 0;
                    lvl[i] = !lvl[i];
                end
            end
            ok[i]  <= !fail[i];
            raw[i] <= fail[i] ? !raw[i] : lvl[i];
        end
    end
endmodule
`default_nettype wire

// ===== bench/glitchless_clock_switch_tb.sv
`default_nettype none
module glitchless_clock_switch_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import clock_switch_pkg::*;
    localparam int ha = 4;
    localparam int hb = 5;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       sel = 1'b0;
    logic       cap = 1'b0;
    logic [1:0] stop = '0;
    logic [1:0] fail = '0;
    logic [1:0] raw;
    logic [1:0] ok;
    logic       clock_out;
    logic       switching;
    logic       active_b;
    logic [2:0] hist [2] = '{3'h0, 3'h0};
    logic       prev_out = 1'b0;
    logic       runt_chk = 1'b0;
    int         run = 0;
    int         error_cnt = 0;
    int         comparisons = 0;

    initial
    begin
        forever #12.5 clk = ~clk;
    end

    clock_source_model #(.half_a(ha), .half_b(hb)) i_src
        (.clk(clk), .stop(stop), .fail(fail), .raw(raw), .ok(ok));

    glitchless_clock_switch #(.por_cycles(4)) i_dut
    (
        .clk(clk), .rst(rst), .clock_input_a(raw[0]), .clock_input_a_ok(ok[0]),
        .clock_input_b(raw[1]), .clock_input_b_ok(ok[1]), .select_b(sel),
        .delay_capacitor_pin(cap), .clock_out(clock_out), .switching(switching), .active_b(active_b)
    );

    always @(posedge clk)
    begin
        hist[0] <= {hist[0][1:0], raw[0]};
        hist[1] <= {hist[1][1:0], raw[1]};
    end

    ////////////////////////////////////////////////////////////////////////////
    // a phase shorter than the faster source's half period is a runt
    always @(negedge clk)
    begin
        if (clock_out === prev_out)
            run++;
        else
        begin
            if (runt_chk)
                cmp_cnt("phase length", run, ha, 99999);
            run = 1;
        end
        prev_out = clock_out;
    end

    task automatic cmp_bit(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic cmp_cnt(input string what, input int got, input int lo, input int hi);
        comparisons++;
        if (got < lo || got > hi)
        begin
            error_cnt++;
            $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic give_up(input string what);
        error_cnt++;
        $display("[ERR] %s expected done seen timeout", what);
        end_of_test();
    endtask

    task automatic wait_sw(input int lim);
        int n;
        n = 0;
        while (switching !== 1'b1)
        begin
            if (++n > lim)
                give_up("switching");
            @(negedge clk);
        end
    endtask

    // clock_out shows the input as sampled one edge before the edge that launched it
    task automatic follow(input logic b, input int n);
        repeat (n)
        begin
            @(negedge clk);
            cmp_bit("follow", hist[b][1], clock_out);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic do_reset();
        runt_chk = 0;
        rst <= 1'b1;
        repeat (6) @(negedge clk);
        cmp_bit("reset out", 1'b0, clock_out | switching | active_b);
        rst <= 1'b0;
        repeat (3)
        begin
            @(negedge clk);
            cmp_bit("init out", 1'b0, clock_out | switching);
        end
        repeat (12) @(negedge clk);
        runt_chk = 1;
        $display("reset done");
    endtask

    // old index is !to_b; handover counted in new-clock rises
    task automatic switch_over(input logic to_b, input logic stuck, input logic lvl, input logic by_fail);
        int   n;
        int   rises;
        int   hi_rises;
        int   bad;
        int   low;
        int   max_low;
        logic prev;
        n = 0;
        while (stuck && hist[!to_b] !== {!lvl, lvl, lvl})
        begin
            if (++n > 40)
                give_up("old phase");
            @(negedge clk);
        end
        if (stuck)
        begin
            if (by_fail)
                fail[!to_b] <= 1'b1;
            else
                stop[!to_b] <= 1'b1;
            repeat (12) @(negedge clk);
            repeat (8)
            begin
                @(negedge clk);
                cmp_bit("held level", lvl, clock_out);
            end
        end
        n = 0;
        rises = 0;
        hi_rises = 0;
        bad = 0;
        low = 0;
        max_low = 0;
        prev = raw[to_b];
        sel <= to_b;
        @(negedge clk);
        cmp_bit("early switching", 1'b0, switching);
        wait_sw(5);
        while (active_b !== to_b)
        begin
            if (++n > 400)
                give_up("handover");
            @(negedge clk);
            rises += raw[to_b] && !prev;
            hi_rises += clock_out && raw[to_b] && !prev;
            bad += stuck && !lvl && clock_out;
            prev = raw[to_b];
            low = clock_out ? 0 : low + 1;
            max_low = low > max_low ? low : max_low;
        end
        cmp_cnt("new rises", rises, 1, max_switch_cycles);
        cmp_cnt("stretched low", max_low, (to_b ? hb : ha) + 1, 400);
        if (stuck && lvl)
            cmp_cnt("held rises", hi_rises, hold_pulses, hold_pulses + 2);
        cmp_cnt("low path highs", bad, 0, 0);
        cmp_bit("switching end", 1'b0, switching);
        follow(to_b, 24);
        fail <= '0;
        stop <= '0;
        $display("switch to %0d stuck %0d done", to_b, stuck);
    endtask

    task automatic bypass_switch();
        int n;
        runt_chk = 0;
        cap <= 1'b1;
        repeat (4) @(negedge clk);
        sel <= 1'b0;
        n = 0;
        while (active_b !== 1'b0)
        begin
            if (++n > 4)
                give_up("bypass");
            @(negedge clk);
            cmp_bit("bypass switching", 1'b0, switching);
        end
        cmp_cnt("bypass delay", n, 3, 4);
        follow(1'b0, 16);
        $display("bypass done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        do_reset();
        follow(1'b0, 24);
        switch_over(1'b1, 1'b0, 1'b0, 1'b0);
        switch_over(1'b0, 1'b0, 1'b0, 1'b0);
        switch_over(1'b1, 1'b1, 1'b1, 1'b0);
        switch_over(1'b0, 1'b1, 1'b0, 1'b1);
        switch_over(1'b1, 1'b1, 1'b1, 1'b1);
        bypass_switch();
        do_reset();
        end_of_test();
    end
endmodule
`default_nettype wire
